// ---- bench/stc_core_bench.sv ----
// self-checking bench for the servo trajectory and encoder core
`default_nettype none
module stc_core_bench import stc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int INIT = 64;
  localparam int TICK = STC_SAMPLE_CYCLES;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_err;
  logic [STC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd_data, va;
  logic [11:0] motor;
  stc_enc_t enc;
  int bad_count, tests_run;
  logic [7:0] zero_regs [6] = '{STC_ACCEL, STC_VMAX, STC_TARGET, STC_KP, STC_KI, STC_KD};
  ////////////////////////////////////////////////////////////
  // design and encoder partner
  stc_core #(.INIT_CYC(INIT)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enc(enc), .host_interrupt_out(irq), .motor_output_port(motor)
  );
  stc_enc_model enc_m (.pclk(pclk), .enc(enc));
  // free-running clock
  always #4 pclk = ~pclk;
  // compare, count and report at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // one apb transfer; an idle edge first so strobes never toggle twice in a step
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      bad_count++;
      conclude();
    end
  endtask : apb
  task automatic rdc(input logic [7:0] addr, input logic [31:0] exp);
    apb(1'b0, addr, 32'h0);
    check(rd_data, exp);
  endtask : rdc
  // poll status until all bits of msk are set; giving up is a failure
  task automatic poll(input logic [31:0] msk, input int gap, input int tries);
    int i;
    for (i = 0; i < tries; i++) begin
      apb(1'b0, STC_STATUS, 32'h0);
      if ((rd_data & msk) === msk) break;
      repeat (gap) @(posedge pclk);
    end
    if (i == tries) begin
      bad_count++;
      conclude();
    end
  endtask : poll
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bad_count = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    check({20'h0, motor}, 32'h800);
    presetn <= 1'b1;
    rdc(STC_STATUS, 32'h0);
    rdc(STC_THRESH, 32'h7FFF);
    rdc(STC_MASK, 32'h3E);
    rdc(STC_POS, 32'h0);
    rdc(STC_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) rdc(zero_regs[i], 32'h0);
    // 32 reads span the scaled 1.5 ms budget
    poll(32'h84, 0, 32);
    check(rd_data, 32'h84);
    apb(1'b1, STC_CMD, 32'h8);
    rdc(STC_STATUS, 32'h80);
    // refused accesses raise the unmasked command error source
    apb(1'b1, 8'h44, 32'hFFFF_FFFF);
    check({31'h0, rd_err}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    rdc(STC_STATUS, 32'h82);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, STC_CMD, 32'h8);
    repeat (3) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    // encoder counting, double jumps dropped, index capture
    repeat (6) enc_m.move(2'h1);
    repeat (2) enc_m.move(2'h3);
    rdc(STC_POS, 32'h4);
    repeat (2) enc_m.move(2'h2);
    rdc(STC_POS, 32'h4);
    apb(1'b1, STC_CMD, 32'h4);
    enc_m.index(1'b0);
    rdc(STC_INDEX, 32'h4);
    check({31'h0, irq}, 32'h1);
    enc_m.index(1'b1);
    apb(1'b1, STC_CMD, 32'h8);
    // position move; target lowered mid-move, so braking must land exactly
    apb(1'b1, STC_ACCEL, 32'h0001_0000);
    apb(1'b1, STC_VMAX, 32'h0001_0000);
    apb(1'b1, STC_TARGET, 32'h64);
    apb(1'b1, STC_CMD, 32'h1);
    repeat (2 * TICK) @(posedge pclk);
    apb(1'b1, STC_TARGET, 32'h8);
    poll(32'h4, 500, 60);
    rdc(STC_DESPOS, 32'h8);
    repeat (TICK + 50) @(posedge pclk);
    rdc(STC_PERR, 32'h4);
    // velocity mode: advance per sample must settle at the commanded 2.0
    apb(1'b1, STC_CTRL, 32'h1);
    apb(1'b1, STC_VMAX, 32'h0002_0000);
    apb(1'b1, STC_CMD, 32'h1);
    repeat (4 * TICK) @(posedge pclk);
    apb(1'b0, STC_DESPOS, 32'h0);
    va = rd_data;
    repeat (TICK - 3) @(posedge pclk);
    apb(1'b0, STC_DESPOS, 32'h0);
    check(rd_data - va, 32'h2);
    // coefficients were never loaded, so the drive must sit at the zero code
    check({20'h0, motor}, 32'h800);
    apb(1'b1, STC_CMD, 32'h2);
    conclude();
  end
endmodule : stc_core_bench
`default_nettype wire

// ---- bench/stc_core_chk.sv ----
// assertion checker for the servo core bus answers and reset drive
`default_nettype none
module stc_core_chk import stc_pkg::*; #(
  parameter int INIT_CYC = stc_pkg::STC_INIT_CYCLES
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic [stc_pkg::STC_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // refusal
  input wire logic [11:0] motor_output_port // motor drive
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////
  // cycles since release; saturates so the windows never wrap
  int unsigned cyc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cyc <= 0;
    else if (cyc < INIT_CYC + 8) cyc <= cyc + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a setup cycle, and one with a misaligned address
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_addr_s;
    setup_s ##0 (paddr[1:0] != 2'h0);
  endsequence
  // windows keep two cycles of slack around the init milestones, four for the status read
  pready_after_setup_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  pready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  misaligned_err_a: assert property (bad_addr_s |=> pready && pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  prdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
    else $error("read answer changed without setup");
  status_zero_a: assert property (
    setup_s ##0 (paddr == STC_STATUS && cyc + 4 < INIT_CYC) |=> prdata == 32'h0)
    else $error("status not zero during init");
  motor_release_a: assert property ($rose(presetn) |-> motor_output_port == STC_MID12)
    else $error("motor not mid-scale at release");
  motor_mid12_a: assert property (cyc + 2 < INIT_CYC / 2 |-> motor_output_port == 12'h800)
    else $error("motor not 12-bit mid-scale");
  motor_mid8_a: assert property (
    cyc > INIT_CYC / 2 + 2 && cyc + 2 < INIT_CYC |-> motor_output_port == 12'h080)
    else $error("motor not 8-bit mid-scale");
endmodule : stc_core_chk
bind stc_core stc_core_chk #(.INIT_CYC(INIT_CYC)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .motor_output_port(motor_output_port)
);
`default_nettype wire

// ---- bench/stc_enc_model.sv ----
// encoder partner: quadrature phases and index switch
`default_nettype none
module stc_enc_model import stc_pkg::*; (
  input wire logic pclk, // system clock
  output var stc_pkg::stc_enc_t enc // encoder pins
);
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////
  // wheel quarter position, gray coded onto the phases
  logic [1:0] q;
  initial begin
    q = 2'h0;
    enc = '{phase_a: 1'b0, phase_b: 1'b0, index_n: 1'b1};
  end
  // dwell after each change so no state is too short to be seen
  task automatic dwell();
    repeat (10) @(posedge pclk);
  endtask : dwell
  // 1 steps forward, 3 back, 2 flips both phases at once
  task automatic move(input logic [1:0] d);
    @(posedge pclk);
    q = q + d;
    enc.phase_a <= q[0] ^ q[1];
    enc.phase_b <= q[1];
    dwell();
  endtask : move
  // switch closure pulls index low; the bench always releases it
  task automatic index(input logic lvl);
    @(posedge pclk);
    enc.index_n <= lvl;
    dwell();
  endtask : index
endmodule : stc_enc_model
`default_nettype wire

// ---- design/stc_core.sv ----
// servo core: apb registers, encoder counter, trajectory, pid output
`default_nettype none
module stc_core #(
  parameter int INIT_CYC = stc_pkg::STC_INIT_CYCLES
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [stc_pkg::STC_AW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped or misaligned
  input wire stc_pkg::stc_enc_t enc, // encoder pins
  output logic host_interrupt_out, // level, active high
  output logic [11:0] motor_output_port // offset binary drive
);
  import stc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // registers and state
  // position and index are raw 32-bit counts; the desired position keeps a
  // 16-bit fraction below its integer part so slow velocities still advance
  logic [31:0] ctrl, accel, vmax, target, brk;
  logic [15:0] kp, ki, kd, thresh;
  logic [7:0] mask, flags;
  logic [31:0] pos, index_pos;
  logic signed [47:0] des_pos;
  logic [31:0] vel;
  logic dir, stopping, armed, init_done;
  stc_traj_t tstate;
  logic [31:0] init_cnt;
  logic [10:0] scnt;
  logic [7:0] dcnt;
  stc_enc_t sync1, sync2, prev;
  logic [23:0] integ;
  logic [15:0] eprev, dterm;
  logic [15:0] e16; // saturated error, also read back over the bus

  ////////////////////////////////////////////////////////////////
  // apb decode
  // every access is answered in exactly one cycle, so the slave never stalls
  // the master; the read word is frozen at the setup edge, which keeps it
  // stable through the access edge even if a counter moves in between
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire aligned = paddr[1:0] == 2'b00;
  // status bit 0 stays low: there is no busy phase since every write lands at once
  wire [31:0] status_w = {24'h0, init_done, flags[6:1], 1'b0};
  wire w_ctrl = wr && paddr == STC_CTRL;
  wire w_cmd = wr && paddr == STC_CMD;
  wire [31:0] cmd = w_cmd ? pwdata : 32'h0;
  wire w_acc = wr && paddr == STC_ACCEL;
  wire w_vmax = wr && paddr == STC_VMAX;
  wire w_tgt = wr && paddr == STC_TARGET;
  wire w_kp = wr && paddr == STC_KP;
  wire w_ki = wr && paddr == STC_KI;
  wire w_kd = wr && paddr == STC_KD;
  wire w_thr = wr && paddr == STC_THRESH;
  wire w_mask = wr && paddr == STC_MASK;
  wire w_brk = wr && paddr == STC_BRK;
  logic [31:0] rd_data;
  logic hit;

  // read mux; unknown addresses answer zero with an error
  always_comb begin
    hit = aligned;
    unique case (paddr)
      STC_CTRL: rd_data = ctrl;
      STC_CMD: rd_data = 32'h0;
      STC_STATUS: rd_data = status_w;
      STC_ACCEL: rd_data = accel;
      STC_VMAX: rd_data = vmax;
      STC_TARGET: rd_data = target;
      STC_KP: rd_data = {16'h0, kp};
      STC_KI: rd_data = {16'h0, ki};
      STC_KD: rd_data = {16'h0, kd};
      STC_THRESH: rd_data = {16'h0, thresh};
      STC_MASK: rd_data = {24'h0, mask};
      STC_POS: rd_data = pos;
      STC_INDEX: rd_data = index_pos;
      STC_DESPOS: rd_data = des_pos[47:16];
      STC_PERR: rd_data = {{16{e16[15]}}, e16};
      STC_BRK: rd_data = brk;
      default: begin
        rd_data = 32'h0;
        hit = 1'b0;
      end
    endcase
  end

  // one access cycle: ready is raised by the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= rd_data;
        pslverr <= ~hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // software registers
  // the mask keeps bits 7 and 0 clear because no source sits there;
  // command writes are not stored, they act only during their access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 32'h0;
      accel <= 32'h0;
      vmax <= 32'h0;
      target <= 32'h0;
      kp <= 16'h0;
      ki <= 16'h0;
      kd <= 16'h0;
      brk <= 32'h0;
      thresh <= STC_THRESH_RST;
      mask <= STC_MASK_RST;
    end else begin
      if (w_ctrl) ctrl <= pwdata;
      if (w_acc) accel <= pwdata;
      if (w_vmax) vmax <= pwdata;
      if (w_tgt) target <= pwdata;
      if (w_kp) kp <= pwdata[15:0];
      if (w_ki) ki <= pwdata[15:0];
      if (w_kd) kd <= pwdata[15:0];
      if (w_thr) thresh <= pwdata[15:0];
      if (w_mask) mask <= {1'b0, pwdata[6:1], 1'b0};
      if (w_brk) brk <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // initialisation sequence after reset release
  // the motor port walks from the 12-bit to the 8-bit zero code halfway
  // through, so either converter width sees its mid-scale during start-up;
  // commands that start motion are refused until the ready bit is up
  wire init_last = init_cnt == 32'(INIT_CYC - 1);
  wire init_half = init_cnt >= 32'(INIT_CYC / 2);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cnt <= 32'h0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_cnt <= init_cnt + 32'h1;
      init_done <= init_last;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sample and derivative dividers
  // both dividers are held until initialisation ends so the first sample
  // falls a full interval after the ready bit; a smaller derivative setting
  // written mid-interval may stretch that one interval by 256 samples
  wire tick = init_done && scnt == 11'(STC_SAMPLE_CYCLES - 1);
  wire dint_end = dcnt == ctrl[STC_CTRL_DINT +: 8];
  wire dtick = tick & dint_end;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scnt <= 11'h0;
      dcnt <= 8'h0;
    end else if (init_done) begin
      scnt <= scnt + 11'h1;
      if (tick) dcnt <= dint_end ? 8'h0 : dcnt + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // encoder sync; only the second and third stages feed the decoder
  // reset values match the idle pins (phases low, index released high), so
  // leaving reset does not look like a step or an index event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '{1'b0, 1'b0, 1'b1};
      sync2 <= '{1'b0, 1'b0, 1'b1};
      prev <= '{1'b0, 1'b0, 1'b1};
    end else begin
      sync1 <= enc;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // one phase changed: a step; both changed: dropped as illegal
  wire da = sync2.phase_a ^ prev.phase_a;
  wire db = sync2.phase_b ^ prev.phase_b;
  wire enc_step = da ^ db;
  // forward order is 00,10,11,01 when A leads B
  wire enc_fwd = prev.phase_b ^ sync2.phase_a;
  wire [31:0] pos_nx = enc_fwd ? pos + 32'h1 : pos - 32'h1;
  // wrap marks a step across the signed limit in either direction
  wire wrap = enc_step && (pos_nx[31] ^ pos[31]) && (pos_nx[30] == pos[31]);
  // index low level only counts while armed; a stuck low index captures once
  wire idx_hit = armed & ~sync2.phase_a & ~sync2.phase_b & ~sync2.index_n;

  // position counter and index capture
  // the captured value is the count before any step taken in the same cycle,
  // which matches what the host would have read at the index moment
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 32'h0;
      index_pos <= 32'h0;
      armed <= 1'b0;
    end else begin
      if (enc_step) pos <= pos_nx;
      if (cmd[STC_CMD_ARM]) armed <= 1'b1;
      else if (idx_hit) armed <= 1'b0;
      if (idx_hit) index_pos <= pos;
    end
  end

  ////////////////////////////////////////////////////////////////
  // trajectory generator, one step per sample tick
  // velocity and acceleration are unsigned 16.16 values; direction is held
  // apart from the speed, and it may only flip while the speed is zero so
  // a retargeted move always brakes to rest before reversing
  function automatic logic [31:0] ramp(input logic [31:0] v, input logic [31:0] goal,
                                       input logic [31:0] a);
    logic [32:0] up;
    logic [32:0] dn;
    up = {1'b0, v} + {1'b0, a};
    dn = {1'b0, v} - {1'b0, a};
    if (v < goal) ramp = (up[32] || up[31:0] > goal) ? goal : up[31:0];
    else if (v > goal) ramp = (dn[32] || dn[31:0] < goal) ? goal : dn[31:0];
    else ramp = v;
  endfunction : ramp

  wire vmode = ctrl[STC_CTRL_VMODE];
  wire [31:0] des_int = des_pos[47:16];
  wire signed [32:0] rem = $signed({target[31], target}) - $signed({des_int[31], des_int});
  wire [32:0] rem_mag = rem[32] ? 33'(-rem) : rem;
  wire toward = (rem != 33'sd0) && (rem[32] == dir);
  wire [63:0] vsq = vel * vel;
  wire [64:0] arem = accel * rem_mag;
  // braking distance v*v/(2a), compared without a divider
  // the products are kept at full width: a 16.16 speed squared needs 64 bits
  // and a truncated compare would brake late on long moves
  wire brake = stopping || !toward || {18'h0, vsq} >= {arem, 17'h0};
  logic [31:0] next_vel;
  logic signed [47:0] next_des;
  logic next_dir, traj_done;
  stc_traj_t next_state;

  always_comb begin
    next_vel = vel;
    next_dir = dir;
    next_state = tstate;
    traj_done = 1'b0;
    if (tstate == STC_MOVE && vmode) begin
      next_dir = (vel == 32'h0) ? ctrl[STC_CTRL_REV] : dir;
      next_vel = ramp(vel, stopping ? 32'h0 : vmax, accel);
      if (stopping && vel == 32'h0) begin
        next_state = STC_HALT;
        traj_done = 1'b1;
      end
    end else if (tstate == STC_MOVE) begin
      if (vel == 32'h0 && (rem == 33'sd0 || stopping)) begin
        next_state = STC_HALT;
        traj_done = 1'b1;
      end else if (vel == 32'h0 && !toward) begin
        next_dir = rem[32];
      end else if (brake) begin
        next_vel = ramp(vel, 32'h0, accel);
      end else begin
        next_vel = ramp(vel, vmax, accel);
      end
    end
    if (next_dir) next_des = des_pos - $signed({16'h0, next_vel});
    else next_des = des_pos + $signed({16'h0, next_vel});
    // close to the end the last fraction is snapped onto the target
    if (tstate == STC_MOVE && !vmode && !stopping && brake && toward &&
        vel <= accel) begin
      next_des = $signed({target, 16'h0});
      next_vel = 32'h0;
    end
    if (tstate != STC_MOVE) next_des = des_pos;
  end

  // a start command wins over stop in the same cycle and acts at once; otherwise
  // only the stop request is latched between ticks, the motion state moving on ticks alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tstate <= STC_IDLE;
      vel <= 32'h0;
      dir <= 1'b0;
      stopping <= 1'b0;
      des_pos <= 48'sh0;
    end else begin
      if (cmd[STC_CMD_START] && init_done) begin
        tstate <= STC_MOVE;
        stopping <= 1'b0;
        if (vel == 32'h0) dir <= vmode ? ctrl[STC_CTRL_REV] : rem[32];
      end else begin
        if (cmd[STC_CMD_STOP]) stopping <= 1'b1;
        if (tick) begin
          tstate <= next_state;
          vel <= next_vel;
          dir <= next_dir;
          des_pos <= next_des;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // position error, saturated to 16 bits for the filter
  // the error is formed at 33 bits so that it cannot overflow before saturation
  wire signed [32:0] err = $signed({des_int[31], des_int}) - $signed({pos[31], pos});
  wire e_hi = !err[32] && err > 33'sd32767;
  wire e_lo = err[32] && err < -33'sd32768;
  assign e16 = e_hi ? 16'h7FFF : e_lo ? 16'h8000 : err[15:0];
  wire [32:0] err_mag = err[32] ? 33'(-err) : err;
  wire perr_hit = tick && err_mag > {17'h0, thresh};

  // pid: p and i each sample, d refreshed at the derivative rate
  // only the low 16 bits of each product are kept, and the integral keeps
  // 24 bits of which the top 8 are used; there is no integration limit,
  // so a large ki with a stuck motor can wind the output around
  wire [15:0] i_top = integ[23:8];
  wire [15:0] i_shift = {{8{i_top[15]}}, i_top[15:8]};
  wire [15:0] p_term = 16'(kp * e16);
  wire [15:0] i_term = 16'(ki * i_shift);
  wire [15:0] u = p_term + i_term + dterm;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ <= 24'h0;
      eprev <= 16'h0;
      dterm <= 16'h0;
      motor_output_port <= STC_MID12;
    end else if (!init_done) begin
      motor_output_port <= init_half ? STC_MID8 : STC_MID12;
    end else if (tick) begin
      integ <= integ + {{8{e16[15]}}, e16};
      if (dtick) begin
        dterm <= 16'(kd * (e16 - eprev));
        eprev <= e16;
      end
      motor_output_port <= {~u[15], u[14:4]};
    end
  end

  ////////////////////////////////////////////////////////////////
  // event flags: a set in the clearing cycle survives
  // a flag stays set until the reset-flags command; the interrupt is the
  // registered or of enabled flags, so it lags the flag by one clock
  logic [7:0] flag_set, flag_clr;
  always_comb begin
    flag_set = 8'h0;
    flag_set[STC_ST_CMDERR] = acc & ~hit | cmd[STC_CMD_START] & ~init_done;
    flag_set[STC_ST_DONE] = init_last & ~init_done | tick & traj_done;
    flag_set[STC_ST_INDEX] = idx_hit;
    flag_set[STC_ST_WRAP] = wrap;
    flag_set[STC_ST_PERR] = perr_hit;
    flag_set[STC_ST_BRK] = tick && pos == brk;
    flag_clr = cmd[STC_CMD_RSTFLG] ? 8'h7E : 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= 8'h0;
      host_interrupt_out <= 1'b0;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set;
      host_interrupt_out <= |(flags & mask);
    end
  end
endmodule : stc_core
`default_nettype wire

// ---- shared/stc_pkg.sv ----
// constants and types of the servo trajectory and encoder core
// Function
// - reset zeroes every filter coefficient and trajectory parameter
// - reset loads the position error threshold with 7FFF hex
// - reset masks the breakpoint source and enables the other five
// - reset sets actual position to zero, the home point
// - reset selects the shortest derivative interval, 2048 clocks
// - motor port shows 800 hex then 80 hex while initialising
// - status reads 00 after reset, then 84 within 1.5 ms
// - flag reset command turns status 84 into 80
// - each quadrature edge counts position up or down by one
// - all encoder inputs are synchronised to the clock first
// - armed capture copies position when A, B and index are low
// - index capture raises the host interrupt
// - each sample, error is desired minus actual position
// - P and I update every 2048 clocks; D every 2048*(n+1)
// - position mode accelerates until max velocity or braking point
// - deceleration uses the programmed acceleration magnitude
// - new max velocity or target is followed during a move
// - velocity mode holds velocity by advancing desired position
// - each sample acceleration is added until velocity is reached
// - parameters are 32 bits; velocity and acceleration are 16.16
// - A leading B by 90 degrees counts forward
// - reset is active low and held at least 8 clocks
`default_nettype none
package stc_pkg;
  localparam int STC_AW = 8;
  // register byte offsets
  localparam logic [7:0] STC_CTRL = 8'h00;
  localparam logic [7:0] STC_CMD = 8'h04;
  localparam logic [7:0] STC_STATUS = 8'h08;
  localparam logic [7:0] STC_ACCEL = 8'h10;
  localparam logic [7:0] STC_VMAX = 8'h14;
  localparam logic [7:0] STC_TARGET = 8'h18;
  localparam logic [7:0] STC_KP = 8'h1C;
  localparam logic [7:0] STC_KI = 8'h20;
  localparam logic [7:0] STC_KD = 8'h24;
  localparam logic [7:0] STC_THRESH = 8'h28;
  localparam logic [7:0] STC_MASK = 8'h2C;
  localparam logic [7:0] STC_POS = 8'h30;
  localparam logic [7:0] STC_INDEX = 8'h34;
  localparam logic [7:0] STC_DESPOS = 8'h38;
  localparam logic [7:0] STC_PERR = 8'h3C;
  localparam logic [7:0] STC_BRK = 8'h40;
  // control and command bit positions
  localparam int STC_CTRL_VMODE = 0;
  localparam int STC_CTRL_REV = 1;
  localparam int STC_CTRL_DINT = 8;
  localparam int STC_CMD_START = 0;
  localparam int STC_CMD_STOP = 1;
  localparam int STC_CMD_ARM = 2;
  localparam int STC_CMD_RSTFLG = 3;
  // status bit positions
  localparam int STC_ST_CMDERR = 1;
  localparam int STC_ST_DONE = 2;
  localparam int STC_ST_INDEX = 3;
  localparam int STC_ST_WRAP = 4;
  localparam int STC_ST_PERR = 5;
  localparam int STC_ST_BRK = 6;
  localparam int STC_ST_READY = 7;
  // reset values
  localparam logic [15:0] STC_THRESH_RST = 16'h7FFF;
  localparam logic [7:0] STC_MASK_RST = 8'h3E;
  localparam logic [11:0] STC_MID12 = 12'h800;
  localparam logic [11:0] STC_MID8 = 12'h080;
  // timing
  localparam int STC_CLK_MHZ = 125;
  localparam int STC_INIT_US = 1000;
  localparam int STC_INIT_CYCLES = STC_INIT_US * STC_CLK_MHZ;
  localparam int STC_SAMPLE_CYCLES = 2048;
  localparam int STC_RESET_MIN_CYCLES = 8;
  typedef struct packed {
    logic phase_a;
    logic phase_b;
    logic index_n;
  } stc_enc_t;
  typedef enum logic [1:0] {STC_IDLE, STC_MOVE, STC_HALT} stc_traj_t;
endpackage : stc_pkg
`default_nettype wire
